// file: design/mna_pkg.sv
// constants, register map and types of the multiply and negate datapath
package mna_pkg;
   // register byte offsets; data register i sits at 4*i
   localparam logic [7:0]  MNA_DREG_OFS    = 8'h00;
   localparam logic [7:0]  MNA_OPW_OFS     = 8'h20;
   localparam logic [7:0]  MNA_EXT_OFS     = 8'h24;
   localparam logic [7:0]  MNA_MEM_OFS     = 8'h28;
   localparam logic [7:0]  MNA_RES_OFS     = 8'h2C;
   localparam logic [7:0]  MNA_CCR_OFS     = 8'h30;
   localparam logic [7:0]  MNA_STAT_OFS    = 8'h34;
   // reset values
   localparam logic [31:0] MNA_WORD_RST    = 32'h0000_0000;
   localparam logic [15:0] MNA_HALF_RST    = 16'h0000;
   localparam logic [4:0]  MNA_CCR_RST     = 5'h00;
   // flag positions in the condition byte
   localparam int          MNA_CC_C        = 0;
   localparam int          MNA_CC_V        = 1;
   localparam int          MNA_CC_Z        = 2;
   localparam int          MNA_CC_N        = 3;
   localparam int          MNA_CC_X        = 4;
   // status bit positions
   localparam int          MNA_ST_BUSY     = 0;
   localparam int          MNA_ST_ILL      = 1;
   localparam int          MNA_ST_DONE     = 2;
   // extension word fields of the long multiply
   localparam int          MNA_EXT_SGN     = 11;
   localparam int          MNA_EXT_SIZE    = 10;
   localparam int          MNA_EXT_LO_LSB  = 12;
   localparam int          MNA_EXT_HI_LSB  = 0;
   // operand size codes
   localparam logic [1:0]  MNA_SZ_BYTE     = 2'b00;
   localparam logic [1:0]  MNA_SZ_WORD     = 2'b01;
   localparam logic [1:0]  MNA_SZ_LONG     = 2'b10;
   // effective address modes
   localparam logic [2:0]  MNA_EA_DREG     = 3'b000;
   localparam logic [2:0]  MNA_EA_AREG     = 3'b001;
   localparam logic [2:0]  MNA_EA_EXT      = 3'b111;
   localparam logic [2:0]  MNA_EA_ABSL     = 3'b001;
   localparam logic [2:0]  MNA_EA_IMM      = 3'b100;
   // opcode patterns
   localparam logic [3:0]  MNA_GRP_MULW    = 4'hC;
   localparam logic [3:0]  MNA_GRP_MISC    = 4'h4;
   localparam logic [1:0]  MNA_MULW_OPM    = 2'b11;
   localparam logic [5:0]  MNA_MULL_PAT    = 6'b110000;
   localparam logic [5:0]  MNA_BCD_PAT     = 6'b100000;
   localparam logic [3:0]  MNA_NEG_PAT     = 4'b0100;
   localparam logic [3:0]  MNA_ZERO_SUBTRACT_WITH_EXTEND_PAT    = 4'b0000;
   // decimal adjust
   localparam logic [3:0]  MNA_BCD_ADJ     = 4'h6;

   typedef enum logic [1:0] {
      MNA_IDLE = 2'b00,
      MNA_EXEC = 2'b01,
      MNA_WB   = 2'b10
   } mna_state_t;

   typedef enum logic [2:0] {
      MNA_OP_MULW = 3'b000,
      MNA_OP_MULL = 3'b001,
      MNA_OP_BCD  = 3'b010,
      MNA_OP_NEG  = 3'b011,
      MNA_OP_ZERO_SUBTRACT_WITH_EXTEND = 3'b100,
      MNA_OP_BAD  = 3'b111
   } mna_op_t;
endpackage

// file: design/mna_exe_if.sv
// operand and result carrier between the core and its arithmetic units
interface mna_exe_if;
   logic        start;
   logic [31:0] mul_a;
   logic [31:0] mul_b;
   logic        mul_sgn;
   logic [63:0] prod;
   logic [31:0] neg_d;
   logic [1:0]  neg_size;
   logic        neg_x;
   logic        neg_bcd;
   logic [31:0] neg_res;
   logic        neg_c;
   logic        neg_v;
   logic        neg_n;
   logic        neg_nz;
   modport core (output start, mul_a, mul_b, mul_sgn, neg_d, neg_size, neg_x, neg_bcd,
                 input  prod, neg_res, neg_c, neg_v, neg_n, neg_nz);
   modport mul  (input start, mul_a, mul_b, mul_sgn, output prod);
   modport neg  (input start, neg_d, neg_size, neg_x, neg_bcd,
                 output neg_res, neg_c, neg_v, neg_n, neg_nz);
endinterface

// file: design/mna_mul.sv
// registered 32x32 multiplier, signed or unsigned
module mna_mul
   import mna_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // operands and product
   mna_exe_if.mul   exe
);
   logic signed [63:0] sprod;
   logic        [63:0] uprod;
   logic        [63:0] prod_ff;

   assign sprod    = $signed(exe.mul_a) * $signed(exe.mul_b);
   assign uprod    = {32'h0000_0000, exe.mul_a} * {32'h0000_0000, exe.mul_b};
   assign exe.prod = prod_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prod_ff <= {MNA_WORD_RST, MNA_WORD_RST};
      else if (exe.start)
         prod_ff <= exe.mul_sgn ? sprod : uprod;
   end
endmodule

// file: design/mna_neg.sv
// registered negate, negate with extend and decimal negate unit
module mna_neg
   import mna_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // operand and result
   mna_exe_if.neg   exe
);
   logic [31:0] dm;
   logic [32:0] diff;
   logic [4:0]  lo5;
   logic [4:0]  hi5;
   logic        lb;
   logic        hb;
   logic [31:0] nxt_res;
   logic        nxt_c;
   logic        nxt_v;
   logic        nxt_n;
   logic [31:0] res_ff;
   logic [3:0]  flg_ff;

   always_comb
   begin
      case (exe.neg_size)
         MNA_SZ_BYTE: dm = {24'h000000, exe.neg_d[7:0]};
         MNA_SZ_WORD: dm = {16'h0000, exe.neg_d[15:0]};
         default:     dm = exe.neg_d;
      endcase
      diff = 33'h0_0000_0000 - {1'b0, dm} - {32'h0000_0000, exe.neg_x};
      lo5  = 5'h00 - {1'b0, exe.neg_d[3:0]} - {4'h0, exe.neg_x};
      lb   = lo5[4];
      hi5  = 5'h00 - {1'b0, exe.neg_d[7:4]} - {4'h0, lb};
      hb   = hi5[4];
      if (exe.neg_bcd)
      begin
         nxt_res = {24'h000000, hb ? hi5[3:0] - MNA_BCD_ADJ : hi5[3:0],
                    lb ? lo5[3:0] - MNA_BCD_ADJ : lo5[3:0]};
         nxt_c   = hb;
         nxt_v   = 1'b0;
         nxt_n   = nxt_res[7];
      end
      else
      begin
         case (exe.neg_size)
            MNA_SZ_BYTE:
            begin
               nxt_res = {24'h000000, diff[7:0]};
               nxt_c   = diff[8];
               nxt_n   = diff[7];
               nxt_v   = dm[7] & diff[7];
            end
            MNA_SZ_WORD:
            begin
               nxt_res = {16'h0000, diff[15:0]};
               nxt_c   = diff[16];
               nxt_n   = diff[15];
               nxt_v   = dm[15] & diff[15];
            end
            default:
            begin
               nxt_res = diff[31:0];
               nxt_c   = diff[32];
               nxt_n   = diff[31];
               nxt_v   = dm[31] & diff[31];
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         res_ff <= MNA_WORD_RST;
         flg_ff <= 4'h0;
      end
      else if (exe.start)
      begin
         res_ff <= nxt_res;
         flg_ff <= {nxt_res != 32'h0000_0000, nxt_n, nxt_v, nxt_c};
      end
   end

   assign exe.neg_res = res_ff;
   assign exe.neg_c   = flg_ff[0];
   assign exe.neg_v   = flg_ff[1];
   assign exe.neg_n   = flg_ff[2];
   assign exe.neg_nz  = flg_ff[3];
endmodule

// file: design/mna_alu_top.sv
// apb-reached multiply and negate execution datapath with its data registers
// Function
// - long multiply takes multiplicand from low product register, writes low word there
// - long size bit 0 returns 32-bit product, 1 returns 64-bit product
// - with size one, upper product word goes to high product register
// - word multiply uses low 16 bits of operands, writes full 32-bit product
// - long multiply with 32-bit result keeps only the low product word
// - multiplies keep extend, clear carry, set negative and zero from result
// - unsigned 32-bit-result long multiply overflows when upper product word nonzero
// - signed 32-bit-result long multiply overflows when upper word is not sign extension
// - long multiplies need data modes; negates need data-alterable destination modes
// - decimal negate is zero minus byte minus extend in packed decimal
// - decimal negate works on bytes only
// - decimal negate sets carry on decimal borrow, extend copies carry
// - decimal negate and negate with extend only clear zero on nonzero result
// - negate subtracts operand from zero at byte, word or long size
// - negate size field 00 byte, 01 word, 10 long
// - negate carry set on nonzero result, extend copies carry, n z v from result
// - negate with extend is zero minus operand minus extend at selected size
// - negate with extend sets carry on borrow, extend copies carry, n and v
module mna_alu_top
   import mna_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   mna_exe_if   exe ();
   mna_state_t  state_ff;
   mna_state_t  nxt_state;
   mna_op_t     op;
   logic [31:0] dreg_ff [8];
   logic [15:0] opw_ff;
   logic [15:0] ext_ff;
   logic [31:0] mem_ff;
   logic [31:0] res_ff;
   logic [4:0]  ccr_ff;
   logic        ill_ff;
   logic        done_ff;
   logic        idle_seen_ff;
   logic [31:0] prdata_ff;
   logic [31:0] rd_mux;
   logic        idle;
   logic        mapped;
   logic        acc;
   logic        wr;
   logic        launch;
   logic [2:0]  ea_mode;
   logic [2:0]  ea_reg;
   logic [2:0]  lo_idx;
   logic [2:0]  hi_idx;
   logic [2:0]  wdst_idx;
   logic        long64;
   logic        sgn;
   logic        ea_data;
   logic        ea_dalt;
   logic        legal;
   logic        dst_reg;
   logic [31:0] src_val;
   logic [31:0] res32;
   logic [31:0] merged;
   logic        wb;
   mna_mul u_mul
   (
      .pclk    (pclk),
      .presetn (presetn),
      .exe     (exe.mul)
   );
   mna_neg u_neg
   (
      .pclk    (pclk),
      .presetn (presetn),
      .exe     (exe.neg)
   );
   // apb handshake; busy datapath stalls every access
   assign idle    = (state_ff == MNA_IDLE);
   assign pready  = penable & idle & idle_seen_ff;
   assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= MNA_STAT_OFS);
   assign pslverr = pready & ~mapped;
   assign acc     = psel & penable & pready;
   assign wr      = acc & pwrite & mapped;
   assign launch  = wr && (paddr == MNA_OPW_OFS);
   assign prdata  = prdata_ff;
   // read data is caught one cycle ahead of pready
   always_comb
   begin
      rd_mux = MNA_WORD_RST;
      if (mapped && paddr < MNA_OPW_OFS)
         rd_mux = dreg_ff[paddr[4:2]];
      else
      begin
         case (paddr)
            MNA_OPW_OFS:  rd_mux = {16'h0000, opw_ff};
            MNA_EXT_OFS:  rd_mux = {16'h0000, ext_ff};
            MNA_MEM_OFS:  rd_mux = mem_ff;
            MNA_RES_OFS:  rd_mux = res_ff;
            MNA_CCR_OFS:  rd_mux = {27'h0000000, ccr_ff};
            MNA_STAT_OFS: rd_mux = {29'h00000000, done_ff, ill_ff, ~idle};
            default:      rd_mux = MNA_WORD_RST;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff    <= MNA_WORD_RST;
         idle_seen_ff <= 1'b0;
      end
      else
      begin
         prdata_ff    <= psel ? rd_mux : prdata_ff;
         idle_seen_ff <= psel & idle;
      end
   end
   // instruction fields
   assign ea_mode = opw_ff[5:3];
   assign ea_reg  = opw_ff[2:0];
   assign lo_idx  = ext_ff[MNA_EXT_LO_LSB +: 3];
   assign hi_idx  = ext_ff[MNA_EXT_HI_LSB +: 3];
   assign wdst_idx = opw_ff[11:9];
   assign long64  = ext_ff[MNA_EXT_SIZE];
   assign ea_data = (ea_mode != MNA_EA_AREG) && !(ea_mode == MNA_EA_EXT && ea_reg > MNA_EA_IMM);
   assign ea_dalt = (ea_mode != MNA_EA_AREG) && !(ea_mode == MNA_EA_EXT && ea_reg > MNA_EA_ABSL);
   assign dst_reg = (ea_mode == MNA_EA_DREG);
   // opcode decode
   always_comb
   begin
      op  = MNA_OP_BAD;
      sgn = 1'b0;
      if (opw_ff[15:12] == MNA_GRP_MULW && opw_ff[7:6] == MNA_MULW_OPM)
      begin
         op  = MNA_OP_MULW;
         sgn = opw_ff[8];
      end
      else if (opw_ff[15:12] == MNA_GRP_MISC)
      begin
         if (opw_ff[11:6] == MNA_MULL_PAT)
         begin
            op  = MNA_OP_MULL;
            sgn = ext_ff[MNA_EXT_SGN];
         end
         else if (opw_ff[11:6] == MNA_BCD_PAT)
            op = MNA_OP_BCD;
         // size 11 is not a negate
         else if (opw_ff[11:8] == MNA_NEG_PAT && opw_ff[7:6] != 2'b11)
            op = MNA_OP_NEG;
         else if (opw_ff[11:8] == MNA_ZERO_SUBTRACT_WITH_EXTEND_PAT && opw_ff[7:6] != 2'b11)
            op = MNA_OP_ZERO_SUBTRACT_WITH_EXTEND;
      end
   end
   assign legal = (op == MNA_OP_MULW || op == MNA_OP_MULL) ? ea_data :
                  (op == MNA_OP_BAD) ? 1'b0 : ea_dalt;
   // register operand, else the operand fetched from memory
   assign src_val = dst_reg ? dreg_ff[ea_reg] : mem_ff;
   // operand steering
   always_comb
   begin
      if (op == MNA_OP_MULW)
      begin
         exe.mul_a = sgn ? {{16{src_val[15]}}, src_val[15:0]} : {16'h0000, src_val[15:0]};
         exe.mul_b = sgn ? {{16{dreg_ff[wdst_idx][15]}}, dreg_ff[wdst_idx][15:0]}
                         : {16'h0000, dreg_ff[wdst_idx][15:0]};
      end
      else
      begin
         exe.mul_a = src_val;
         exe.mul_b = dreg_ff[lo_idx];
      end
   end
   assign exe.start    = (state_ff == MNA_EXEC);
   assign exe.mul_sgn  = sgn;
   assign exe.neg_d    = src_val;
   assign exe.neg_size = (op == MNA_OP_BCD) ? MNA_SZ_BYTE : opw_ff[7:6];
   assign exe.neg_bcd  = (op == MNA_OP_BCD);
   assign exe.neg_x    = (op == MNA_OP_NEG) ? 1'b0 : ccr_ff[MNA_CC_X];
   // sized negate result merged into the untouched upper register bits
   always_comb
   begin
      case (exe.neg_size)
         MNA_SZ_BYTE: merged = {src_val[31:8], exe.neg_res[7:0]};
         MNA_SZ_WORD: merged = {src_val[31:16], exe.neg_res[15:0]};
         default:     merged = exe.neg_res;
      endcase
   end
   // 32-bit result is the low product word for multiplies, the merged word for negates
   assign res32 = (op == MNA_OP_MULW || op == MNA_OP_MULL) ? exe.prod[31:0] : merged;
   assign wb    = (state_ff == MNA_WB) && legal;
   // sequencer: launch, execute, write back
   always_comb
   begin
      case (state_ff)
         MNA_IDLE: nxt_state = launch ? MNA_EXEC : MNA_IDLE;
         MNA_EXEC: nxt_state = MNA_WB;
         MNA_WB:   nxt_state = MNA_IDLE;
         default:  nxt_state = MNA_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_ff <= MNA_IDLE;
      else
         state_ff <= nxt_state;
   end
   // software-written instruction and operand registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         opw_ff <= MNA_HALF_RST;
         ext_ff <= MNA_HALF_RST;
         mem_ff <= MNA_WORD_RST;
      end
      else if (wr)
      begin
         if (paddr == MNA_OPW_OFS)
            opw_ff <= pwdata[15:0];
         if (paddr == MNA_EXT_OFS)
            ext_ff <= pwdata[15:0];
         if (paddr == MNA_MEM_OFS)
            mem_ff <= pwdata;
      end
   end
   // data registers; busy blocks apb so the two writers never meet
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 8; i++)
            dreg_ff[i] <= MNA_WORD_RST;
      end
      else if (wr && paddr < MNA_OPW_OFS)
         dreg_ff[paddr[4:2]] <= pwdata;
      else if (wb)
      begin
         case (op)
            MNA_OP_MULW:
               dreg_ff[wdst_idx] <= exe.prod[31:0];
            MNA_OP_MULL:
            begin
               // upper word to high product register
               if (long64)
                  dreg_ff[hi_idx] <= exe.prod[63:32];
               // equal indices leave the low word, result undefined anyway
               dreg_ff[lo_idx] <= exe.prod[31:0];
            end
            default:
               if (dst_reg)
                  dreg_ff[ea_reg] <= merged;
         endcase
      end
   end
   // result word for memory destinations
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         res_ff <= MNA_WORD_RST;
      else if (wb)
         res_ff <= res32;
   end
   // condition flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ccr_ff <= MNA_CCR_RST;
      else if (wr && paddr == MNA_CCR_OFS)
         ccr_ff <= pwdata[4:0];
      else if (wb)
      begin
         case (op)
            MNA_OP_MULW, MNA_OP_MULL:
            begin
               ccr_ff[MNA_CC_C] <= 1'b0;
               if (op == MNA_OP_MULL && long64)
               begin
                  ccr_ff[MNA_CC_N] <= exe.prod[63];
                  ccr_ff[MNA_CC_Z] <= (exe.prod == 64'h0);
                  ccr_ff[MNA_CC_V] <= 1'b0;
               end
               else
               begin
                  ccr_ff[MNA_CC_N] <= exe.prod[31];
                  ccr_ff[MNA_CC_Z] <= (exe.prod[31:0] == 32'h0000_0000);
                  if (op == MNA_OP_MULW)
                     ccr_ff[MNA_CC_V] <= 1'b0;
                  // signed overflow, upper not sign extension
                  else if (sgn)
                     ccr_ff[MNA_CC_V] <= (exe.prod[63:32] != {32{exe.prod[31]}});
                  else
                     ccr_ff[MNA_CC_V] <= (exe.prod[63:32] != 32'h0000_0000);
               end
            end
            MNA_OP_BCD:
            begin
               // decimal borrow to carry and extend
               ccr_ff[MNA_CC_C] <= exe.neg_c;
               ccr_ff[MNA_CC_X] <= exe.neg_c;
               if (exe.neg_nz)
                  ccr_ff[MNA_CC_Z] <= 1'b0;
            end
            MNA_OP_NEG:
            begin
               ccr_ff[MNA_CC_C] <= exe.neg_nz;
               ccr_ff[MNA_CC_X] <= exe.neg_nz;
               ccr_ff[MNA_CC_N] <= exe.neg_n;
               ccr_ff[MNA_CC_Z] <= ~exe.neg_nz;
               ccr_ff[MNA_CC_V] <= exe.neg_v;
            end
            default:
            begin
               ccr_ff[MNA_CC_C] <= exe.neg_c;
               ccr_ff[MNA_CC_X] <= exe.neg_c;
               ccr_ff[MNA_CC_N] <= exe.neg_n;
               ccr_ff[MNA_CC_V] <= exe.neg_v;
               if (exe.neg_nz)
                  ccr_ff[MNA_CC_Z] <= 1'b0;
            end
         endcase
      end
   end
   // status: a new launch clears both, completion sets done and loads ill from the legality check
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ill_ff  <= 1'b0;
         done_ff <= 1'b0;
      end
      else if (state_ff == MNA_WB)
      begin
         ill_ff  <= ~legal;
         done_ff <= 1'b1;
      end
      else if (launch)
      begin
         ill_ff  <= 1'b0;
         done_ff <= 1'b0;
      end
   end
endmodule

// file: testbench/mna_alu_props.sv
// apb-side property checker of the multiply and negate datapath
module mna_alu_props
   import mna_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   logic acc;
   logic go;
   assign acc = psel && penable && pready;
   // an opword write launches the datapath
   assign go  = acc && pwrite && paddr == MNA_OPW_OFS;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; pready |-> psel && penable; endproperty
   a_rdy: assert property (p_rdy) else $error("ready outside access");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_map; acc |-> pslverr == (paddr[1:0] != 2'h0 || paddr > MNA_STAT_OFS); endproperty
   a_map: assert property (p_map) else $error("error flag wrong");
   property p_ez; acc && pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_ez: assert property (p_ez) else $error("refused read data");
   property p_zw; acc && !go ##1 psel && !penable ##1 psel && penable |-> pready; endproperty
   a_zw: assert property (p_zw) else $error("wait state when idle");
   property p_busy; go |-> ##2 !pready ##1 !pready; endproperty
   a_busy: assert property (p_busy) else $error("answer during busy");
   property p_stall; go ##1 psel && !penable ##1 psel && penable |-> !pready [*2] ##1 pready;
   endproperty
   a_stall: assert property (p_stall) else $error("stall length wrong");
   property p_hold; !$past(psel) |-> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind mna_alu_top mna_alu_props mna_alu_props_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr);

// file: testbench/mna_apb_host.sv
// apb master standing in for the decode and operand fetch side
module mna_apb_host
(
   // clock
   input  wire logic        pclk,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   // called just after an edge; leaves the access asserted so transfers chain
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
   endtask
   // released lines show no stale value
   task automatic idle();
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~paddr;
      pwdata  <= ~pwdata;
      @(posedge pclk);
   endtask
endmodule

// file: testbench/test_mna_alu_top.sv
// self-checking bench of the multiply and negate datapath
module test_mna_alu_top
   import mna_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          fails = 0;
   int          tests_run = 0;
   always #5ns pclk = ~pclk;
   mna_alu_top mna_alu_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   mna_apb_host mna_apb_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x)
      begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      mna_apb_host_inst.xfer(w, a, d, r, e);
      if (!w)
         cmp(r, x);
      cmp({31'h0, e}, {31'h0, xe});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xf(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      xf(1'b0, a, 32'h0, x, 1'b0);
   endtask
   // status read stalls until write-back; done set, busy clear
   task automatic op(input logic [15:0] w);
      wr(MNA_OPW_OFS, {16'h0, w});
      rd(MNA_STAT_OFS, 32'h4);
   endtask
   task automatic un(input logic [15:0] w, input logic [7:0] a,
                     input logic [31:0] d, c, xd, xc);
      wr(MNA_CCR_OFS, c);
      wr(a, d);
      op(w);
      rd(a, xd);
      rd(MNA_CCR_OFS, xc);
   endtask
   task automatic t_reset();
      rd(8'h00, 32'h0);
      rd(MNA_CCR_OFS, 32'h0);
      rd(MNA_STAT_OFS, 32'h0);
      xf(1'b0, 8'h38, 32'h0, 32'h0, 1'b1);
      xf(1'b1, 8'h06, 32'hFFFF, 32'h0, 1'b1);
      rd(8'h04, 32'h0);
      wr(MNA_RES_OFS, 32'h5);
      rd(MNA_RES_OFS, 32'h0);
      wr(MNA_CCR_OFS, 32'hFFFFFFFF);
      rd(MNA_CCR_OFS, 32'h1F);
      $display("end t_reset");
   endtask
   task automatic t_mulw();
      wr(8'h04, 32'hFFFF0003);
      un(16'hC4C1, 8'h08, 32'h12340004, 32'h13, 32'hC, 32'h10);
      wr(8'h04, 32'h0000FFFE);
      un(16'hC5C1, 8'h08, 32'h3, 32'h13, 32'hFFFFFFFA, 32'h18);
      un(16'hC4C1, 8'h08, 32'h12340000, 32'h13, 32'h0, 32'h14);
      $display("end t_mulw");
   endtask
   task automatic t_mull();
      logic [15:0] ex [3] = '{16'h3000, 16'h3800, 16'h3404};
      logic [31:0] cc [3] = '{32'h1A, 32'h18, 32'h10};
      wr(MNA_MEM_OFS, 32'h5);
      // high and low registers differ
      for (int i = 0; i < 3; i++)
      begin
         wr(MNA_EXT_OFS, {16'h0, ex[i]});
         un(16'h4C39, 8'h0C, 32'hFFFFFFFF, 32'h11, 32'hFFFFFFFB, cc[i]);
         rd(8'h10, (i == 2) ? 32'h4 : 32'h0);
      end
      // misaligned read near a live register must come back empty
      xf(1'b0, 8'h11, 32'h0, 32'h0, 1'b1);
      wr(MNA_EXT_OFS, 32'h3800);
      un(16'h4C39, 8'h0C, 32'h40000000, 32'h11, 32'h40000000, 32'h12);
      $display("end t_mull");
   endtask
   task automatic t_neg();
      un(16'h4806, 8'h18, 32'hFF000025, 32'h04, 32'hFF000075, 32'h11);
      un(16'h4806, 8'h18, 32'h25, 32'h10, 32'h74, 32'h11);
      un(16'h4806, 8'h18, 32'h0, 32'h04, 32'h0, 32'h04);
      un(16'h4407, 8'h1C, 32'hAB000001, 32'h0, 32'hAB0000FF, 32'h19);
      un(16'h4447, 8'h1C, 32'h12348000, 32'h0, 32'h12348000, 32'h1B);
      un(16'h4487, 8'h1C, 32'h0, 32'h1F, 32'h0, 32'h04);
      un(16'h4080, 8'h00, 32'h1, 32'h14, 32'hFFFFFFFE, 32'h19);
      un(16'h4080, 8'h00, 32'h0, 32'h04, 32'h0, 32'h04);
      un(16'h4000, 8'h00, 32'h80, 32'h0, 32'h80, 32'h1B);
      un(16'h4040, 8'h00, 32'hFFFF, 32'h10, 32'h0, 32'h11);
      wr(MNA_MEM_OFS, 32'h5);
      op(16'h4490);
      rd(MNA_RES_OFS, 32'hFFFFFFFB);
      $display("end t_neg");
   endtask
   task automatic t_bad();
      logic [15:0] bw [4] = '{16'h44C7, 16'h4488, 16'h4C08, 16'h483C};
      logic [31:0] r;
      logic        e;
      wr(8'h1C, 32'h55);
      wr(MNA_CCR_OFS, 32'h0A);
      foreach (bw[i])
      begin
         wr(MNA_OPW_OFS, {16'h0, bw[i]});
         mna_apb_host_inst.xfer(1'b0, MNA_STAT_OFS, 32'h0, r, e);
         cmp({31'h0, r[MNA_ST_ILL]}, 32'h1);
         rd(8'h1C, 32'h55);
         rd(MNA_CCR_OFS, 32'h0A);
      end
      $display("end t_bad");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // whole run needs about 350 cycles
   initial
   begin
      #100us;
      fails++;
      close_out();
   end
   initial
   begin
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_mulw();
      t_mull();
      t_neg();
      t_bad();
      mna_apb_host_inst.idle();
      close_out();
   end
endmodule
